/* File: core/mpfc_pause_tx.sv */
/*
 Pause frame generator: one byte per link clock, 60 bytes of frame
 followed by 4 FCS bytes. Assumes start is a one-cycle pulse given
 only while busy is low, with address and quantum stable beside it.
*/
`timescale 1ns/10ps
`default_nettype none

module mpfc_pause_tx
   import mpfc_pkg::*;
(
   input wire logic linkClk,
   input wire logic rstn,
   mpfc_ptx_if.gen tx
);

   typedef struct packed {
      mpfc_gen_state_t st;
      logic [6:0] idx;
      logic [31:0] crc;
      logic [47:0] sa;
      logic [15:0] quantum;
      logic [7:0] data;
      logic valid;
      logic last;
   } mpfc_gen_t;

   mpfc_gen_t g_r;
   mpfc_gen_t g_nxt;

   // Byte sequencer and running FCS
   always_comb begin
      logic [7:0] b;
      logic [2:0] j;
      b = FILL_BYTE;
      j = 3'(g_r.idx - 7'(ADDR_BYTES));
      g_nxt = g_r;
      g_nxt.valid = 1'b0;
      g_nxt.last = 1'b0;
      case (g_r.st)
         GEN_IDLE: begin
            if (tx.start) begin
               g_nxt.st = GEN_SEND;
               g_nxt.idx = 7'h00;
               g_nxt.crc = CRC_INIT;
               g_nxt.sa = tx.srcAddr;
               g_nxt.quantum = tx.quantum;
            end
         end
         GEN_SEND: begin
            if (g_r.idx < 7'(ADDR_BYTES)) begin
               b = 8'(PAUSE_DA >> {3'd5 - g_r.idx[2:0], 3'b000});
            end else if (g_r.idx < 7'(2 * ADDR_BYTES)) begin
               b = 8'(g_r.sa >> {3'd5 - j, 3'b000});
            end else if (g_r.idx < 7'(2 * ADDR_BYTES + 2)) begin
               b = g_r.idx[0] ? MAC_CTL_TYPE[7:0] : MAC_CTL_TYPE[15:8];
            end else if (g_r.idx < 7'(2 * ADDR_BYTES + 4)) begin
               b = g_r.idx[0] ? PAUSE_OPCODE[7:0] : PAUSE_OPCODE[15:8];
            end else if (g_r.idx < 7'(HDR_BYTES)) begin
               b = g_r.idx[0] ? g_r.quantum[7:0] : g_r.quantum[15:8];
            end else if (g_r.idx < 7'(MIN_FRAME_BYTES)) begin
               b = FILL_BYTE;
            end else begin
               b = 8'(~g_r.crc >> {g_r.idx[1:0], 3'b000});
            end
            if (g_r.idx < 7'(MIN_FRAME_BYTES)) begin
               g_nxt.crc = mpfc_crc_byte(g_r.crc, b);
            end
            g_nxt.data = b;
            g_nxt.valid = 1'b1;
            g_nxt.idx = g_r.idx + 7'h01;
            if (g_r.idx == 7'(MIN_FRAME_BYTES + FCS_BYTES - 1)) begin
               g_nxt.last = 1'b1;
               g_nxt.st = GEN_IDLE;
            end
         end
         default: g_nxt.st = GEN_IDLE;
      endcase
   end

   always_ff @(posedge linkClk or negedge rstn) begin
      if (!rstn) begin
         g_r <= '0;
      end else begin
         g_r <= g_nxt;
      end
   end

   // Outputs from the state flops, busy is the send state ORed with valid
   assign tx.busy = (g_r.st == GEN_SEND) | g_r.valid;
   assign tx.valid = g_r.valid;
   assign tx.last = g_r.last;
   assign tx.data = g_r.data;

endmodule : mpfc_pause_tx

`default_nettype wire

/* File: core/mpfc_pkg.sv */
/*
 Shared constants for the MAC pause flow control block: register map,
 field positions, reset values, frame constants and the CRC step.
 Assumes a 32-bit register port with 12-bit byte addresses.
*/
package mpfc_pkg;

   // Register byte offsets
   localparam logic [11:0] OFS_NCR = 12'h000;
   localparam logic [11:0] OFS_NCFG = 12'h004;
   localparam logic [11:0] OFS_STAT = 12'h008;
   localparam logic [11:0] OFS_ISR = 12'h024;
   localparam logic [11:0] OFS_IMR = 12'h030;
   localparam logic [11:0] OFS_QUANT = 12'h038;
   localparam logic [11:0] OFS_SA1L = 12'h088;
   localparam logic [11:0] OFS_SA1H = 12'h08C;
   localparam logic [11:0] OFS_PRXCNT = 12'h16C;

   // Field positions
   localparam int NCR_TXEN = 3;
   localparam int NCR_TXPQ = 11;
   localparam int NCR_TXPZ = 12;
   localparam int CFG_FD = 1;
   localparam int CFG_RETRY = 12;
   localparam int CFG_RXPE = 13;
   localparam int CFG_PFC = 16;
   localparam int ISR_PNZ = 12;
   localparam int ISR_PZ = 13;
   localparam int STAT_PAUSED = 0;

   // Reset values
   localparam logic RST_BIT = 1'b0;
   localparam logic [15:0] QUANT_RST = 16'h0000;
   localparam logic [47:0] SA1_RST = 48'h0000_0000_0000;
   localparam logic [31:0] CNT_RST = 32'h0000_0000;

   // Frame constants
   localparam logic [47:0] PAUSE_DA = 48'h0180_C200_0001;
   localparam logic [15:0] MAC_CTL_TYPE = 16'h8808;
   localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
   localparam logic [7:0] FILL_BYTE = 8'h00;
   localparam int ADDR_BYTES = 6;
   localparam int HDR_BYTES = 18;
   localparam int MIN_FRAME_BYTES = 60;
   localparam int FCS_BYTES = 4;

   // Pause slot timing, in bit times, on a byte-wide link
   localparam int SLOT_BIT_TIMES = 512;
   localparam int LINK_BITS_PER_CYCLE = 8;
   localparam int SLOT_CYCLES = SLOT_BIT_TIMES / LINK_BITS_PER_CYCLE;

   localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;

   typedef enum logic {
      GEN_IDLE = 1'b0,
      GEN_SEND = 1'b1
   } mpfc_gen_state_t;

   // One byte of the reflected Ethernet CRC, LSB first
   function automatic logic [31:0] mpfc_crc_byte(input logic [31:0] crc, input logic [7:0] data);
      logic [31:0] c;
      c = crc ^ {24'h00_0000, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : mpfc_crc_byte

endpackage : mpfc_pkg

/* File: core/mpfc_ptx_if.sv */
/*
 Link-side bundle between the pause controller and the pause frame
 generator. Both ends run on the transmit reference clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface mpfc_ptx_if;
   logic start;
   logic [47:0] srcAddr;
   logic [15:0] quantum;
   logic busy;
   logic valid;
   logic last;
   logic [7:0] data;
   modport ctl(output start, srcAddr, quantum, input busy, valid, last, data);
   modport gen(input start, srcAddr, quantum, output busy, valid, last, data);
endinterface : mpfc_ptx_if

`default_nettype wire

/* File: core/mpfc_top.sv */
/*
 MAC pause flow control: register port on sys_clk, pause reception,
 pause timer and pause frame transmission on the transmit reference
 clock. Assumes the MAC core drives the receive byte stream and the
 transmit activity flag from that same clock, and starts a new frame
 only while txHoldOff is low.
*/
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module mpfc_top
   import mpfc_pkg::*;
#(
   parameter int SLOT_LEN = SLOT_CYCLES
)(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [31:0] regRdData,
   input wire logic transmitReferenceClock,
   input wire logic rxByteValid,
   input wire logic [7:0] rxByte,
   input wire logic rxFrameEnd,
   input wire logic rxFrameErr,
   input wire logic txFrameActive,
   output logic txHoldOff,
   output logic ptxValid,
   output logic [7:0] ptxData,
   output logic ptxLast,
   output logic pauseIrqNz,
   output logic pauseIrqZero
);

   localparam int SLOT_W = $clog2(SLOT_LEN);
   localparam int HDR_W = 8 * HDR_BYTES;

   typedef struct packed {
      logic txEn;
      logic fullDup;
      logic retryTest;
      logic rxPauseEn;
      logic pfcNeg;
      logic imrNz;
      logic imrZe;
      logic isrNz;
      logic isrZe;
      logic irqNz;
      logic irqZe;
      logic [15:0] quantum;
      logic [47:0] sa1;
      logic [31:0] pauseRxCnt;
      logic [31:0] rdData;
      logic [4:0] syA;
      logic [4:0] syB;
      logic [4:0] syC;
      logic dirty;
      logic sendReq;
      logic xferBusy;
      logic xferTgl;
      logic xferSend;
      logic [47:0] xferSa;
      logic [15:0] xferQ;
   } mpfc_sys_t;

   typedef struct packed {
      logic [3:0] cfgA;
      logic [3:0] cfgB;
      logic [2:0] xS;
      logic ackTgl;
      logic [47:0] sa1;
      logic [15:0] quantum;
      logic sendPend;
      logic start;
      logic [4:0] rxCnt;
      logic [HDR_W-1:0] hdr;
      logic [15:0] pauseCnt;
      logic [SLOT_W-1:0] slotCnt;
      logic nzTgl;
      logic zeTgl;
      logic stTgl;
      logic holdOff;
      logic paused;
   } mpfc_link_t;

   mpfc_sys_t sys_r;
   mpfc_sys_t sys_nxt;
   mpfc_link_t lnk_r;
   mpfc_link_t lnk_nxt;

   mpfc_ptx_if ptx();

   mpfc_pause_tx u_gen (
      .linkClk(transmitReferenceClock),
      .rstn(rstn),
      .tx(ptx.gen)
   );

   // ---------------- Register side, sys_clk ----------------

   always_comb begin
      logic wrNcr;
      logic nzEv;
      logic zeEv;
      logic stEv;
      logic ackEv;
      wrNcr = regWrStb && (regAddr == OFS_NCR);
      nzEv = sys_r.syB[0] ^ sys_r.syC[0];
      zeEv = sys_r.syB[1] ^ sys_r.syC[1];
      stEv = sys_r.syB[2] ^ sys_r.syC[2];
      ackEv = sys_r.syB[3] ^ sys_r.syC[3];
      sys_nxt = sys_r;
      sys_nxt.rdData = CNT_RST;

      // Link events cross as toggles: two flops, then edge detect
      sys_nxt.syA = {lnk_r.paused, lnk_r.ackTgl, lnk_r.stTgl, lnk_r.zeTgl, lnk_r.nzTgl};
      sys_nxt.syB = sys_r.syA;
      sys_nxt.syC = sys_r.syB;

      // Sticky status, a new event beats a same-cycle clear
      if (regWrStb && (regAddr == OFS_ISR)) begin
         if (regWrData[ISR_PNZ]) begin
            sys_nxt.isrNz = 1'b0;
         end
         if (regWrData[ISR_PZ]) begin
            sys_nxt.isrZe = 1'b0;
         end
      end
      if (nzEv) begin
         sys_nxt.isrNz = 1'b1;
      end
      if (zeEv) begin
         sys_nxt.isrZe = 1'b1;
      end
      if (stEv) begin
         sys_nxt.pauseRxCnt = sys_r.pauseRxCnt + 32'h0000_0001;
      end

      // Masked interrupt lines
      sys_nxt.irqNz = sys_nxt.isrNz & sys_r.imrNz;
      sys_nxt.irqZe = sys_nxt.isrZe & sys_r.imrZe;

      // Word handshake toward the link: hold words until acknowledged
      if (ackEv) begin
         sys_nxt.xferBusy = 1'b0;
      end
      if (sys_r.dirty && !sys_r.xferBusy) begin
         sys_nxt.xferSa = sys_r.sa1;
         sys_nxt.xferQ = sys_r.quantum;
         sys_nxt.xferSend = sys_r.sendReq;
         sys_nxt.xferTgl = ~sys_r.xferTgl;
         sys_nxt.xferBusy = 1'b1;
         sys_nxt.dirty = 1'b0;
         sys_nxt.sendReq = 1'b0;
      end

      // Register writes
      if (wrNcr) begin
         sys_nxt.txEn = regWrData[NCR_TXEN];
         if ((regWrData[NCR_TXPQ] || regWrData[NCR_TXPZ]) && sys_r.fullDup && regWrData[NCR_TXEN]) begin
            sys_nxt.sendReq = 1'b1;
            sys_nxt.dirty = 1'b1;
         end
      end else if (regWrStb && (regAddr == OFS_NCFG)) begin
         sys_nxt.fullDup = regWrData[CFG_FD];
         sys_nxt.retryTest = regWrData[CFG_RETRY];
         sys_nxt.rxPauseEn = regWrData[CFG_RXPE];
         sys_nxt.pfcNeg = regWrData[CFG_PFC];
      end else if (regWrStb && (regAddr == OFS_IMR)) begin
         sys_nxt.imrNz = regWrData[ISR_PNZ];
         sys_nxt.imrZe = regWrData[ISR_PZ];
      end else if (regWrStb && (regAddr == OFS_QUANT)) begin
         sys_nxt.quantum = regWrData[15:0];
         sys_nxt.dirty = 1'b1;
      end else if (regWrStb && (regAddr == OFS_SA1L)) begin
         sys_nxt.sa1[31:0] = regWrData;
         sys_nxt.dirty = 1'b1;
      end else if (regWrStb && (regAddr == OFS_SA1H)) begin
         sys_nxt.sa1[47:32] = regWrData[15:0];
         sys_nxt.dirty = 1'b1;
      end

      // Register reads, data valid the cycle after the strobe
      if (regRdStb) begin
         if (regAddr == OFS_NCR) begin
            sys_nxt.rdData[NCR_TXEN] = sys_r.txEn;
         end else if (regAddr == OFS_NCFG) begin
            sys_nxt.rdData[CFG_FD] = sys_r.fullDup;
            sys_nxt.rdData[CFG_RETRY] = sys_r.retryTest;
            sys_nxt.rdData[CFG_RXPE] = sys_r.rxPauseEn;
            sys_nxt.rdData[CFG_PFC] = sys_r.pfcNeg;
         end else if (regAddr == OFS_STAT) begin
            sys_nxt.rdData[STAT_PAUSED] = sys_r.syB[4];
         end else if (regAddr == OFS_ISR) begin
            sys_nxt.rdData[ISR_PNZ] = sys_r.isrNz;
            sys_nxt.rdData[ISR_PZ] = sys_r.isrZe;
         end else if (regAddr == OFS_IMR) begin
            sys_nxt.rdData[ISR_PNZ] = sys_r.imrNz;
            sys_nxt.rdData[ISR_PZ] = sys_r.imrZe;
         end else if (regAddr == OFS_QUANT) begin
            sys_nxt.rdData[15:0] = sys_r.quantum;
         end else if (regAddr == OFS_SA1L) begin
            sys_nxt.rdData = sys_r.sa1[31:0];
         end else if (regAddr == OFS_SA1H) begin
            sys_nxt.rdData[15:0] = sys_r.sa1[47:32];
         end else if (regAddr == OFS_PRXCNT) begin
            sys_nxt.rdData = sys_r.pauseRxCnt;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sys_r <= '0;
         sys_r.quantum <= QUANT_RST;
         sys_r.sa1 <= SA1_RST;
         sys_r.txEn <= RST_BIT;
      end else begin
         sys_r <= sys_nxt;
      end
   end

   // ---------------- Link side, transmit reference clock ----------------

   always_comb begin
      logic [HDR_W-1:0] hdrNow;
      logic [4:0] cntNow;
      logic fd;
      logic retry;
      logic rxPe;
      logic pfc;
      logic fieldsOk;
      logic pauseOk;
      logic qNz;
      logic stopped;
      logic expire;
      fd = lnk_r.cfgB[3];
      retry = lnk_r.cfgB[2];
      rxPe = lnk_r.cfgB[1];
      pfc = lnk_r.cfgB[0];
      hdrNow = lnk_r.hdr;
      cntNow = lnk_r.rxCnt;
      if (rxByteValid && (lnk_r.rxCnt < 5'(HDR_BYTES))) begin
         hdrNow = {lnk_r.hdr[HDR_W-9:0], rxByte};
         cntNow = lnk_r.rxCnt + 5'd1;
      end
      fieldsOk = ((hdrNow[HDR_W-1 -: 48] == PAUSE_DA) || (hdrNow[HDR_W-1 -: 48] == lnk_r.sa1))
         && (hdrNow[47:32] == MAC_CTL_TYPE) && (hdrNow[31:16] == PAUSE_OPCODE);
      pauseOk = rxFrameEnd && !rxFrameErr && (cntNow == 5'(HDR_BYTES)) && fieldsOk && !pfc;
      qNz = (hdrNow[15:0] != 16'h0000);
      stopped = !txFrameActive && !ptx.busy && !lnk_r.start;
      expire = 1'b0;
      lnk_nxt = lnk_r;
      lnk_nxt.start = 1'b0;

      // Configuration levels, two flops
      lnk_nxt.cfgA = {sys_r.fullDup, sys_r.retryTest, sys_r.rxPauseEn, sys_r.pfcNeg};
      lnk_nxt.cfgB = lnk_r.cfgA;

      // Word handshake: words are stable while the toggle is pending
      lnk_nxt.xS = {lnk_r.xS[1:0], sys_r.xferTgl};
      if (lnk_r.xS[2] ^ lnk_r.xS[1]) begin
         lnk_nxt.sa1 = sys_r.xferSa;
         lnk_nxt.quantum = sys_r.xferQ;
         if (sys_r.xferSend) begin
            lnk_nxt.sendPend = 1'b1;
         end
         lnk_nxt.ackTgl = ~lnk_r.ackTgl;
      end

      // Header capture, restarted by every frame end
      lnk_nxt.hdr = hdrNow;
      lnk_nxt.rxCnt = rxFrameEnd ? 5'd0 : cntNow;

      // Pause timer: reload on every valid frame in full duplex with receive pause enabled, else count down once stopped
      if (pauseOk && fd && rxPe) begin
         lnk_nxt.pauseCnt = hdrNow[15:0];
         lnk_nxt.slotCnt = '0;
      end else if ((lnk_r.pauseCnt != 16'h0000) && stopped) begin
         if (retry || (lnk_r.slotCnt == SLOT_W'(SLOT_LEN - 1))) begin
            lnk_nxt.pauseCnt = lnk_r.pauseCnt - 16'h0001;
            lnk_nxt.slotCnt = '0;
            expire = (lnk_r.pauseCnt == 16'h0001);
         end else begin
            lnk_nxt.slotCnt = lnk_r.slotCnt + SLOT_W'(1);
         end
      end

      // Events toward the register side, raised in either duplex mode
      lnk_nxt.stTgl = lnk_r.stTgl ^ pauseOk;
      lnk_nxt.nzTgl = lnk_r.nzTgl ^ (pauseOk && qNz);
      lnk_nxt.zeTgl = lnk_r.zeTgl ^ ((pauseOk && !qNz) || expire);

      // Pause frame goes out once the hold-off has been seen and the line is free
      if (lnk_r.sendPend && lnk_r.holdOff && !txFrameActive && !ptx.busy) begin
         lnk_nxt.start = 1'b1;
         lnk_nxt.sendPend = 1'b0;
      end

      // Hold off new frames while paused or a pause frame is due
      lnk_nxt.holdOff = (lnk_nxt.pauseCnt != 16'h0000) || lnk_nxt.sendPend
         || lnk_nxt.start || ptx.busy;
      lnk_nxt.paused = (lnk_nxt.pauseCnt != 16'h0000);
   end

   always_ff @(posedge transmitReferenceClock or negedge rstn) begin
      if (!rstn) begin
         lnk_r <= '0;
         lnk_r.sa1 <= SA1_RST;
         lnk_r.quantum <= QUANT_RST;
      end else begin
         lnk_r <= lnk_nxt;
      end
   end

   // Generator control
   assign ptx.start = lnk_r.start;
   assign ptx.srcAddr = lnk_r.sa1;
   assign ptx.quantum = lnk_r.quantum;

   // Outputs, all from flops
   assign regRdData = sys_r.rdData;
   assign pauseIrqNz = sys_r.irqNz;
   assign pauseIrqZero = sys_r.irqZe;
   assign txHoldOff = lnk_r.holdOff;
   assign ptxValid = ptx.valid;
   assign ptxData = ptx.data;
   assign ptxLast = ptx.last;

endmodule : mpfc_top

`default_nettype wire

/* File: sim/mac_pause_flow_control_tb.sv */
/*
 Bench for mpfc_top with a link partner and a byte model of pause frames.
 Assumes SLOT_LEN of 4 link cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module mac_pause_flow_control_tb;
   import mpfc_pkg::*;
   localparam logic [47:0] RES_DA = 48'h0180_C200_0001;
   logic sys_clk = 1'b0, transmitReferenceClock = 1'b0;
   logic rstn = 1'b0, regWrStb = 1'b0, regRdStb = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [31:0] regWrData = 32'h0000_0000, regRdData, c;
   logic rxByteValid, rxFrameEnd, rxFrameErr, txFrameActive, txHoldOff;
   logic ptxValid, ptxLast, pauseIrqNz, pauseIrqZero;
   logic [7:0] rxByte, ptxData;
   logic [7:0] e[$];
   logic [47:0] sa;
   logic [15:0] q;
   logic [143:0] h;
   int bad_count = 0, total_checks = 0, cnt = 0, hc = 0, cyc = 0;
   // Clocks, link clock offset in phase
   initial forever #2.5 sys_clk = ~sys_clk;
   initial begin
      #1.3;
      forever #6 transmitReferenceClock = ~transmitReferenceClock;
   end
   mpfc_top #(.SLOT_LEN(4)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
      .transmitReferenceClock(transmitReferenceClock), .rxByteValid(rxByteValid), .rxByte(rxByte),
      .rxFrameEnd(rxFrameEnd), .rxFrameErr(rxFrameErr), .txFrameActive(txFrameActive),
      .txHoldOff(txHoldOff), .ptxValid(ptxValid), .ptxData(ptxData), .ptxLast(ptxLast),
      .pauseIrqNz(pauseIrqNz), .pauseIrqZero(pauseIrqZero));
   mpfc_link_partner i_mac (.clk(transmitReferenceClock), .rxByteValid(rxByteValid),
      .rxByte(rxByte), .rxFrameEnd(rxFrameEnd), .rxFrameErr(rxFrameErr),
      .txFrameActive(txFrameActive), .ptxValid(ptxValid), .ptxData(ptxData));
   // Link cycles spent held off, and the hang limit
   always @(posedge transmitReferenceClock) begin
      if (txHoldOff) begin
         hc++;
      end
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chkb(input logic got, exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge sys_clk);
      regWrStb <= 1'b0;
   endtask : wr
   task automatic rc(input logic [11:0] a, input logic [31:0] x);
      @(posedge sys_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      #1;
      chk(regRdData, x);
   endtask : rc
   task automatic hold(input logic v, input int n);
      for (int i = 0; i < n && txHoldOff !== v; i++) @(posedge sys_clk);
      chkb(txHoldOff, v);
      repeat (4) @(posedge sys_clk); // Link events need three flops to reach the status bits
   endtask : hold
   task automatic pf(input logic [15:0] v);
      hc = 0;
      i_mac.send(RES_DA, 16'h8808, 16'h0001, v, 1'b0);
      repeat (12) @(posedge sys_clk);
   endtask : pf
   function automatic logic [31:0] crc_of(input logic [7:0] b[$]);
      logic [31:0] r;
      r = 32'hFFFF_FFFF;
      foreach (b[i]) begin
         r ^= {24'h00_0000, b[i]};
         for (int k = 0; k < 8; k++) r = (r >> 1) ^ (r[0] ? 32'hEDB8_8320 : 32'h0000_0000);
      end
      return ~r;
   endfunction : crc_of
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   // Main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      void'($urandom(32'hf9a3_9aba));
      rc(OFS_ISR, 32'h0000_0000);
      rc(OFS_PRXCNT, 32'h0000_0000);
      wr(12'h0FC, 32'hFFFF_FFFF);
      rc(12'h0FC, 32'h0000_0000);
      $display("test reset done");
      wr(OFS_NCFG, 32'h0000_2002);
      wr(OFS_IMR, 32'h0000_3000);
      pf(16'h0003);
      cnt++;
      hold(1'b1, 1);
      rc(OFS_ISR, 32'h0000_1000);
      chkb(pauseIrqNz, 1'b1);
      rc(OFS_PRXCNT, cnt);
      hold(1'b0, 300);
      chkb(hc >= 11 && hc <= 14, 1'b1);
      rc(OFS_ISR, 32'h0000_3000);
      chkb(pauseIrqZero, 1'b1);
      wr(OFS_IMR, 32'h0000_0000);
      repeat (3) @(posedge sys_clk);
      chkb(pauseIrqNz | pauseIrqZero, 1'b0);
      wr(OFS_ISR, 32'h0000_3000);
      wr(OFS_IMR, 32'h0000_3000);
      pf(16'h00C8);
      pf(16'h0000);
      cnt += 2;
      hold(1'b0, 20);
      rc(OFS_ISR, 32'h0000_3000);
      wr(OFS_ISR, 32'h0000_3000);
      wr(OFS_NCFG, 32'h0000_2000);
      pf(16'h0005);
      cnt++;
      chkb(hc == 0, 1'b1);
      rc(OFS_ISR, 32'h0000_1000);
      wr(OFS_ISR, 32'h0000_3000);
      wr(OFS_NCFG, 32'h0001_2002);
      pf(16'h0005);
      chkb(hc == 0, 1'b1);
      rc(OFS_PRXCNT, cnt);
      wr(OFS_NCFG, 32'h0000_3002);
      i_mac.busy(1'b1);
      pf(16'h0008);
      cnt++;
      repeat (20) @(posedge sys_clk);
      hold(1'b1, 1);
      rc(OFS_STAT, 32'h0000_0001);
      i_mac.busy(1'b0);
      hc = 0;
      hold(1'b0, 60);
      chkb(hc >= 7 && hc <= 10, 1'b1);
      wr(OFS_ISR, 32'h0000_3000);
      $display("test receive done");
      sa = 48'({$urandom(), $urandom()});
      q = 16'($urandom());
      wr(OFS_SA1L, sa[31:0]);
      wr(OFS_SA1H, {16'h0000, sa[47:32]});
      wr(OFS_QUANT, {16'h0000, q});
      rc(OFS_QUANT, {16'h0000, q});
      h = {RES_DA, sa, 32'h8808_0001, q};
      for (int i = 17; i >= 0; i--) e.push_back(h[i*8 +: 8]);
      repeat (42) e.push_back(8'h00);
      c = crc_of(e);
      for (int i = 0; i < 4; i++) e.push_back(c[i*8 +: 8]);
      for (int b = 11; b <= 12; b++) begin
         // Refused request: half duplex first, then transmitter disabled
         wr(OFS_NCFG, b == 12 ? 32'h0000_0002 : 32'h0000_0000);
         wr(OFS_NCR, (b == 11 ? 32'h0000_0008 : 32'h0000_0000) | (32'h0000_0001 << b));
         repeat (40) @(posedge sys_clk);
         chk(i_mac.cap.size(), 32'h0000_0000);
         wr(OFS_NCFG, 32'h0000_0002);
         i_mac.busy(b == 12);
         wr(OFS_NCR, 32'h0000_0008 | (32'h0000_0001 << b));
         if (b == 12) begin
            repeat (40) @(posedge sys_clk);
            chk(i_mac.cap.size(), 32'h0000_0000);
            i_mac.busy(1'b0);
         end
         for (int i = 0; i < 400 && i_mac.cap.size() < 64; i++) @(posedge sys_clk);
         chk(i_mac.cap.size(), 32'h0000_0040);
         foreach (e[i]) chk({24'h00_0000, i_mac.cap[i]}, {24'h00_0000, e[i]});
         i_mac.cap.delete();
         hold(1'b0, 20);
      end
      $display("test transmit done");
      // Error, wrong type, wrong opcode, foreign address, own address
      for (int k = 0; k < 5; k++) begin
         i_mac.send(k == 4 ? sa : (k == 3 ? 48'h0180_C200_0002 : RES_DA), k == 1 ? 16'h0800 : 16'h8808,
            k == 2 ? 16'h0002 : 16'h0001, 16'h0000, k == 0);
         repeat (12) @(posedge sys_clk);
         cnt += (k == 4);
         rc(OFS_ISR, k == 4 ? 32'h0000_2000 : 32'h0000_0000);
         rc(OFS_PRXCNT, cnt);
         wr(OFS_ISR, 32'h0000_3000);
      end
      $display("test validity done");
      tally_and_finish();
   end
endmodule : mac_pause_flow_control_tb
`default_nettype wire

/* File: sim/mpfc_link_partner.sv */
/*
 Link partner model: sends receive frames, collects pause frame bytes.
 Assumes one byte per transmit reference clock.
*/
`timescale 1ns/10ps
`default_nettype none
module mpfc_link_partner (
   input wire logic clk,
   output logic rxByteValid,
   output logic [7:0] rxByte,
   output logic rxFrameEnd,
   output logic rxFrameErr,
   output logic txFrameActive,
   input wire logic ptxValid,
   input wire logic [7:0] ptxData
);
   logic [7:0] cap[$];
   // Idle link at time zero
   initial begin
      rxByteValid = 1'b0;
      rxByte = 8'h00;
      rxFrameEnd = 1'b0;
      rxFrameErr = 1'b0;
      txFrameActive = 1'b0;
   end
   // Collect outgoing pause frame bytes
   always @(posedge clk) begin
      if (ptxValid) begin
         cap.push_back(ptxData);
      end
   end
   // One 18-byte control frame, error flag with the last byte
   task automatic send(input logic [47:0] da, input logic [15:0] ty, op, q, input logic err);
      logic [143:0] f;
      f = {da, 48'h0200_0000_0042, ty, op, q};
      for (int i = 17; i >= 0; i--) begin
         @(posedge clk);
         rxByteValid <= 1'b1;
         rxByte <= f[i*8 +: 8];
         rxFrameEnd <= (i == 0);
         rxFrameErr <= err && (i == 0);
      end
      @(posedge clk);
      rxByteValid <= 1'b0;
      rxByte <= ~f[7:0]; // Idle shows inverse of last byte
      rxFrameEnd <= 1'b0;
      rxFrameErr <= 1'b0;
   endtask : send
   // MAC's own frame on the wire, changed just after a link edge
   task automatic busy(input logic v);
      @(posedge clk);
      txFrameActive <= v;
   endtask : busy
endmodule : mpfc_link_partner
`default_nettype wire

/* File: sim/mpfc_props.sv */
/*
 Checker on mpfc_top ports: read data slot and pause frame bytes.
 Assumes the bind below; both clock domains share rstn.
*/
`timescale 1ns/10ps
`default_nettype none
module mpfc_props (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic regRdStb,
   input wire logic [31:0] regRdData,
   input wire logic transmitReferenceClock,
   input wire logic txFrameActive,
   input wire logic txHoldOff,
   input wire logic ptxValid,
   input wire logic [7:0] ptxData,
   input wire logic ptxLast
);
   logic [6:0] vCnt_r;
   // Index of the pause frame byte on the wire
   always_ff @(posedge transmitReferenceClock or negedge rstn) begin
      if (!rstn) begin
         vCnt_r <= 7'h00;
      end else begin
         vCnt_r <= ptxValid ? vCnt_r + 7'h01 : 7'h00;
      end
   end
   a_rd_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
      !$past(regRdStb) |-> regRdData == 32'h0000_0000) else $error("read data outside slot");
   a_last_count: assert property (@(posedge transmitReferenceClock) disable iff (!rstn)
      ptxLast |-> ptxValid && vCnt_r == 7'h3F) else $error("last flag not on byte 63");
   a_valid_end: assert property (@(posedge transmitReferenceClock) disable iff (!rstn)
      $fell(ptxValid) |-> $past(ptxLast)) else $error("frame cut short");
   a_da_first: assert property (@(posedge transmitReferenceClock) disable iff (!rstn)
      ptxValid && vCnt_r == 7'h00 |-> ptxData == 8'h01) else $error("bad first byte");
   a_type_op: assert property (@(posedge transmitReferenceClock) disable iff (!rstn)
      ptxValid && vCnt_r == 7'h0C |-> ptxData == 8'h88 ##1 ptxData == 8'h08 ##1 ptxData == 8'h00
      ##1 ptxData == 8'h01) else $error("bad type or opcode");
   a_fill_zero: assert property (@(posedge transmitReferenceClock) disable iff (!rstn)
      ptxValid && vCnt_r >= 7'h12 && vCnt_r < 7'h3C |-> ptxData == 8'h00) else $error("fill not zero");
   a_hold_sending: assert property (@(posedge transmitReferenceClock) disable iff (!rstn)
      ptxValid |-> txHoldOff) else $error("hold low while sending");
   a_gen_delay: assert property (@(posedge transmitReferenceClock) disable iff (!rstn)
      $rose(ptxValid) |-> $past(txHoldOff && !txFrameActive, 2)) else $error("frame start early");
endmodule : mpfc_props
bind mpfc_top mpfc_props i_props (.*);
`default_nettype wire
